/* tb/fine_delay_measure_tb.sv */
// Self-checking bench for the fine delay measurement block
`timescale 1ns/1ps
`default_nettype none
`include "fine_delay_cfg.svh"

module fine_delay_measure_tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic        smp_clk = 1'b0;
	logic        mrst_n = 1'b1;
	logic [5:0]  tx_lvl = 6'h00;
	logic [5:0]  rx_lvl = 6'h00;
	logic        irq;
	logic [31:0] exp_q[$];
	logic [5:0]  t[6];
	logic [5:0]  r[6];
	logic [31:0] v;
	int          errors = 0;
	int          total_checks = 0;
	int          seed = 1;
	int          cycles = 0;

	fine_delay_measure #(
		.PERIOD_W (8),
		.OCC_W    (6),
		.ACC_W    (23)
	) i_fine_delay_measure (
		.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .meas_sample_clock(smp_clk),
		.meas_reset_n(mrst_n), .tx_buf_level(tx_lvl), .rx_buf_level(rx_lvl),
		.irq(irq)
	);

	// Clock of 100 ns period
	always #50 core_clk = ~core_clk;

	task automatic chk32(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Cycle ceiling cuts a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	// Takes the oldest note off the queue at each read answer
	always @(posedge core_clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() > 0) chk32("read data", exp_q.pop_front(), rdat);
			else chk1("read note present", 1'b1, 1'b0);
		end
	end

	// One classic cycle, held until ack is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		// Wait for the answer; only the cycle ceiling ends a hang
		do begin
			@(posedge core_clk);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
		chk1("ack drops", 1'b0, ack);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000, 4'hf);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		bus(1'b1, a, d, s);
	endtask

	// One sample: levels settle, sampling input high h cycles, low h
	task automatic smp(input logic [5:0] tl, input logic [5:0] rl,
			input int h);
		tx_lvl <= tl;
		rx_lvl <= rl;
		smp_clk <= 1'b1;
		repeat (h) @(posedge core_clk);
		smp_clk <= 1'b0;
		repeat (h) @(posedge core_clk);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk1("irq", 1'b0, irq);
		rd(`FD_OFS_TX_FINE, 32'h0000_0000);
		rd(`FD_OFS_RX_FINE, 32'h0000_0000);
		rd(8'h70, 32'h0000_0000);
		wr(8'h70, 32'hffff_ffff, 4'hf);
		wr(`FD_OFS_IRQ_MASK, 32'h0000_0003, 4'h1);
		wr(`FD_OFS_TX_FINE, 32'hffff_ff02, 4'h1);
		wr(`FD_OFS_RX_FINE, 32'h0000_0003, 4'h1);
		rd(`FD_OFS_TX_FINE, 32'h0000_0002);
		rd(`FD_OFS_RX_FINE, 32'h0000_0003);
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			t[i] = v[5:0];
			r[i] = v[13:8];
			smp(t[i], r[i], 2);
		end
		repeat (3) @(posedge core_clk);
		chk1("irq", 1'b1, irq);
		rd(`FD_OFS_TX_FINE, {1'b1, 23'(t[4]) + 23'(t[5]), 8'h02});
		rd(`FD_OFS_TX_FINE, {1'b0, 23'(t[4]) + 23'(t[5]), 8'h02});
		rd(`FD_OFS_RX_FINE,
			{1'b1, 23'(r[3]) + 23'(r[4]) + 23'(r[5]), 8'h03});
		rd(`FD_OFS_TX_STATUS, {26'h0, t[5]});
		rd(`FD_OFS_IRQ_STAT, 32'h0000_0003);
		wr(`FD_OFS_IRQ_STAT, 32'h0000_0001, 4'h1);
		chk1("irq", 1'b1, irq);
		wr(`FD_OFS_IRQ_MASK, 32'h0000_0001, 4'h1);
		chk1("irq", 1'b0, irq);
		wr(`FD_OFS_IRQ_MASK, 32'h0000_0003, 4'h0);
		rd(`FD_OFS_IRQ_MASK, 32'h0000_0001);
		rd(`FD_OFS_IRQ_STAT, 32'h0000_0002);
		wr(`FD_OFS_IRQ_STAT, 32'h0000_0002, 4'h1);
		rd(`FD_OFS_IRQ_STAT, 32'h0000_0000);
		// Measurement reset clears sums and flags, keeps N
		mrst_n <= 1'b0;
		@(posedge core_clk);
		mrst_n <= 1'b1;
		@(posedge core_clk);
		rd(`FD_OFS_TX_FINE, 32'h0000_0002);
		rd(`FD_OFS_RX_FINE, 32'h0000_0003);
		// N of zero stops the Tx window
		wr(`FD_OFS_TX_FINE, 32'h0000_0000, 4'h1);
		repeat (4) smp(6'h3f, 6'h01, 2);
		rd(`FD_OFS_TX_FINE, 32'h0000_0000);
		// Sampling input at its fastest rate, high one core cycle and low one
		wr(`FD_OFS_TX_FINE, 32'h0000_0001, 4'h1);
		v = $random(seed);
		smp(v[5:0], v[13:8], 1);
		smp(v[21:16], v[29:24], 1);
		rd(`FD_OFS_TX_FINE, {1'b1, 17'h0_0000, v[21:16], 8'h01});
		chk1("read notes drained", 1'b1, exp_q.size() == 0);
		stop_test();
	end
endmodule
`default_nettype wire

/* verilog/fine_delay_cfg.svh */
// Register map, field layout, widths and reset values of the fine delay block
`ifndef FINE_DELAY_CFG_SVH
`define FINE_DELAY_CFG_SVH

// Default widths
`define FD_ADR_W        8
`define FD_PERIOD_W     8
`define FD_OCC_W        6
`define FD_ACC_W        23
`define FD_DATA_W       32
`define FD_SEL_W        4

// Byte offsets of the registers
`define FD_OFS_TX_STATUS 8'h4C
`define FD_OFS_TX_FINE   8'h50
`define FD_OFS_RX_FINE   8'h54
`define FD_OFS_IRQ_STAT  8'h60
`define FD_OFS_IRQ_MASK  8'h64

// Fine delay register layout
`define FD_PERIOD_LSB   0
`define FD_DELAY_LSB    8
`define FD_FRESH_BIT    31

// Interrupt status and mask layout
`define FD_IRQ_W        2
`define FD_IRQ_TX_BIT   0
`define FD_IRQ_RX_BIT   1

// Reset values
`define FD_RST_PERIOD   8'h00
`define FD_RST_IRQ      2'h0
`define FD_RST_WORD     32'h0000_0000

`endif

/* verilog/fine_delay_channel.sv */
// One direction of the fine delay measurement: occupancy accumulator
`timescale 1ns/1ps
`default_nettype none
`include "fine_delay_cfg.svh"

module fine_delay_channel #(
	parameter int PERIOD_W = `FD_PERIOD_W,
	parameter int OCC_W    = `FD_OCC_W,
	parameter int ACC_W    = `FD_ACC_W
) (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                meas_clr,
	input  wire logic                sample_en,
	input  wire logic [PERIOD_W-1:0] period_n,
	input  wire logic [OCC_W-1:0]    occupancy,
	output var  logic [ACC_W-1:0]    sum_o,
	output var  logic                load_o
);
	import fine_delay_pkg::*;

	// The sum of N samples must never wrap
	if (PERIOD_W + OCC_W > ACC_W) begin : g_bad_width
		$error("accumulator too narrow for period and occupancy");
	end

	typedef struct packed {
		meas_state_t         state;
		logic [PERIOD_W-1:0] cnt;
		logic [ACC_W-1:0]    acc;
		logic [ACC_W-1:0]    sum;
		logic                load;
	} chan_t;

	chan_t s_q;
	chan_t s_d;

	// Next state: sample on each sampling edge, unload after N samples
	always_comb begin
		logic [ACC_W-1:0] acc_next;
		acc_next = s_q.acc + ACC_W'(occupancy);
		s_d = s_q;
		s_d.load = 1'b0;
		case (s_q.state)
			MS_IDLE: begin
				s_d.cnt = '0;
				s_d.acc = '0;
				if (!meas_clr && period_n != '0) begin
					s_d.state = MS_ACCUM;
				end
			end
			MS_ACCUM: begin
				if (meas_clr || period_n == '0) begin
					s_d.state = MS_IDLE;
				end else if (sample_en) begin
					if (s_q.cnt >= period_n - 1'b1) begin
						s_d.sum  = acc_next;
						s_d.load = 1'b1;
						s_d.cnt  = '0;
						s_d.acc  = '0;
					end else begin
						s_d.cnt = s_q.cnt + 1'b1;
						s_d.acc = acc_next;
					end
				end
			end
			default: begin
				s_d.state = MS_IDLE;
			end
		endcase
		if (meas_clr) begin
			s_d.sum = '0;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q.state <= MS_IDLE;
			s_q.cnt   <= '0;
			s_q.acc   <= '0;
			s_q.sum   <= '0;
			s_q.load  <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sum_o  = s_q.sum;
	assign load_o = s_q.load;

	// While accumulating, the accumulator only moves on a sampling edge
	a_sample_gate: assert property (
		@(posedge core_clk) disable iff (rst)
		(s_q.state == MS_ACCUM && !sample_en && !meas_clr
		 && period_n != '0) |=> $stable(s_q.acc) && $stable(s_q.cnt))
		else $error("accumulator moved without a sampling edge");

	// Measurement reset empties the channel
	a_meas_reset: assert property (
		@(posedge core_clk) disable iff (rst)
		meas_clr |=> s_q.state == MS_IDLE && sum_o == '0 && !load_o)
		else $error("measurement reset did not clear the channel");

	// The Nth sample loads the full sum
	a_window_load: assert property (
		@(posedge core_clk) disable iff (rst)
		(s_q.state == MS_ACCUM && sample_en && !meas_clr
		 && period_n != '0 && s_q.cnt == period_n - 1'b1)
		|=> load_o && sum_o == $past(s_q.acc) + ACC_W'($past(occupancy))
		 ##1 !load_o)
		else $error("sum not loaded after N samples");

endmodule
`default_nettype wire

/* verilog/fine_delay_measure.sv */
// Fine buffer delay measurement with Wishbone registers and interrupt
// How it works
// - Each direction keeps a software-written period count N of samples.
// - Summing N occupancy samples gives the delay resolved to N/lcm(N,M).
// - A status register shows the present Tx buffer word count.
// - With N nonzero the fine delay field always shows the latest sum.
// - A fresh flag is set by each new sum and cleared by reading it.
// - Rx works like Tx, with its own register at offset 0x54.
// - Measurement is timed by the separate sampling clock for both ways.
// - An active-low measurement reset clears the measurement logic.
`timescale 1ns/1ps
`default_nettype none
`include "fine_delay_cfg.svh"

module fine_delay_measure #(
	parameter int PERIOD_W = `FD_PERIOD_W,
	parameter int OCC_W    = `FD_OCC_W,
	parameter int ACC_W    = `FD_ACC_W
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [`FD_ADR_W-1:0]  wb_adr_i,
	input  wire logic [`FD_SEL_W-1:0]  wb_sel_i,
	input  wire logic [`FD_DATA_W-1:0] wb_dat_i,
	output var  logic [`FD_DATA_W-1:0] wb_dat_o,
	output var  logic                  wb_ack_o,
	input  wire logic                  meas_sample_clock,
	input  wire logic                  meas_reset_n,
	input  wire logic [OCC_W-1:0]      tx_buf_level,
	input  wire logic [OCC_W-1:0]      rx_buf_level,
	output var  logic                  irq
);
	import fine_delay_pkg::*;

	// Field layout must fit a data word and one byte lane for N
	if (PERIOD_W > `FD_DELAY_LSB || PERIOD_W < 1) begin : g_bad_period
		$error("period width must fit the low byte lane");
	end
	if (`FD_DELAY_LSB + ACC_W > `FD_FRESH_BIT) begin : g_bad_acc
		$error("delay field overlaps the fresh flag");
	end
	if (OCC_W > `FD_DATA_W) begin : g_bad_occ
		$error("occupancy wider than a data word");
	end

	typedef struct packed {
		logic                  sample_prev;
		logic [PERIOD_W-1:0]   tx_period;
		logic [PERIOD_W-1:0]   rx_period;
		logic                  tx_fine_delay_fresh;
		logic                  rx_fine_delay_fresh;
		logic [OCC_W-1:0]      tx_level;
		logic [`FD_IRQ_W-1:0]  irq_stat;
		logic [`FD_IRQ_W-1:0]  irq_mask;
		logic                  ack;
		logic [`FD_DATA_W-1:0] rdat;
		logic                  irq;
	} top_t;

	top_t s_q;
	top_t s_d;

	logic                  sample_en;
	logic                  meas_clr;
	logic                  bus_req;
	logic                  bus_rd;
	logic                  bus_wr;
	reg_sel_t              bus_sel;
	logic [ACC_W-1:0]      tx_fine_delay;
	logic [ACC_W-1:0]      rx_fine_delay;
	logic                  tx_load;
	logic                  rx_load;
	logic [PERIOD_W-1:0]   wdat_period;
	logic [`FD_IRQ_W-1:0]  wdat_irq;
	logic [`FD_IRQ_W-1:0]  irq_events;

	// Map a byte address onto a register, word aligned
	function automatic reg_sel_t decode(input logic [`FD_ADR_W-1:0] adr);
		logic [`FD_ADR_W-1:0] word;
		word = {adr[`FD_ADR_W-1:2], 2'b00};
		case (word)
			`FD_OFS_TX_STATUS: decode = SEL_TX_STATUS;
			`FD_OFS_TX_FINE:   decode = SEL_TX_FINE;
			`FD_OFS_RX_FINE:   decode = SEL_RX_FINE;
			`FD_OFS_IRQ_STAT:  decode = SEL_IRQ_STAT;
			`FD_OFS_IRQ_MASK:  decode = SEL_IRQ_MASK;
			default:           decode = SEL_NONE;
		endcase
	endfunction

	// Assemble a fine delay register word
	function automatic logic [`FD_DATA_W-1:0] pack_fine(
		input logic [PERIOD_W-1:0] period,
		input logic [ACC_W-1:0]    delay,
		input logic                fresh
	);
		logic [`FD_DATA_W-1:0] w;
		w = `FD_RST_WORD;
		w[`FD_PERIOD_LSB +: PERIOD_W] = period;
		w[`FD_DELAY_LSB +: ACC_W]     = delay;
		w[`FD_FRESH_BIT]              = fresh;
		pack_fine = w;
	endfunction

	// Sampling clock is a synchronous input; its rising edge is the strobe
	assign sample_en = meas_sample_clock & ~s_q.sample_prev;
	assign meas_clr  = ~meas_reset_n;

	// Classic Wishbone: one request per ack, ack drops the cycle after
	assign bus_req     = wb_cyc_i & wb_stb_i & ~s_q.ack;
	assign bus_rd      = bus_req & ~wb_we_i;
	assign bus_wr      = bus_req & wb_we_i;
	assign bus_sel     = decode(wb_adr_i);
	assign wdat_period = wb_dat_i[`FD_PERIOD_LSB +: PERIOD_W];
	assign wdat_irq    = wb_dat_i[`FD_IRQ_W-1:0];

	// Both directions run the same accumulator
	fine_delay_channel #(
		.PERIOD_W (PERIOD_W),
		.OCC_W    (OCC_W),
		.ACC_W    (ACC_W)
	) u_tx_chan (
		.core_clk  (core_clk),
		.rst       (rst),
		.meas_clr  (meas_clr),
		.sample_en (sample_en),
		.period_n  (s_q.tx_period),
		.occupancy (tx_buf_level),
		.sum_o     (tx_fine_delay),
		.load_o    (tx_load)
	);

	fine_delay_channel #(
		.PERIOD_W (PERIOD_W),
		.OCC_W    (OCC_W),
		.ACC_W    (ACC_W)
	) u_rx_chan (
		.core_clk  (core_clk),
		.rst       (rst),
		.meas_clr  (meas_clr),
		.sample_en (sample_en),
		.period_n  (s_q.rx_period),
		.occupancy (rx_buf_level),
		.sum_o     (rx_fine_delay),
		.load_o    (rx_load)
	);

	// Interrupt events are the loads of a new sum
	always_comb begin
		irq_events = '0;
		irq_events[`FD_IRQ_TX_BIT] = tx_load;
		irq_events[`FD_IRQ_RX_BIT] = rx_load;
	end

	// Next state of registers, bus answer and interrupt
	always_comb begin
		s_d = s_q;
		s_d.sample_prev = meas_sample_clock;
		s_d.tx_level    = tx_buf_level;
		s_d.ack         = bus_req;
		s_d.rdat        = `FD_RST_WORD;

		// Read data, unmapped addresses read as zero
		if (bus_rd) begin
			case (bus_sel)
				SEL_TX_STATUS: begin
					s_d.rdat[OCC_W-1:0] = s_q.tx_level;
				end
				SEL_TX_FINE: begin
					s_d.rdat = pack_fine(s_q.tx_period, tx_fine_delay,
						s_q.tx_fine_delay_fresh);
				end
				SEL_RX_FINE: begin
					s_d.rdat = pack_fine(s_q.rx_period, rx_fine_delay,
						s_q.rx_fine_delay_fresh);
				end
				SEL_IRQ_STAT: begin
					s_d.rdat[`FD_IRQ_W-1:0] = s_q.irq_stat;
				end
				SEL_IRQ_MASK: begin
					s_d.rdat[`FD_IRQ_W-1:0] = s_q.irq_mask;
				end
				default: begin
					s_d.rdat = `FD_RST_WORD;
				end
			endcase
		end

		// Writes through the low byte lane; unmapped writes are dropped
		if (bus_wr && wb_sel_i[0]) begin
			case (bus_sel)
				SEL_TX_FINE: begin
					s_d.tx_period = wdat_period;
				end
				SEL_RX_FINE: begin
					s_d.rx_period = wdat_period;
				end
				SEL_IRQ_STAT: begin
					s_d.irq_stat = s_q.irq_stat & ~wdat_irq;
				end
				SEL_IRQ_MASK: begin
					s_d.irq_mask = wdat_irq;
				end
				default: begin
					s_d.irq_mask = s_q.irq_mask;
				end
			endcase
		end

		// Fresh flags: a read clears, a new sum in the same cycle wins
		if (bus_rd && bus_sel == SEL_TX_FINE) begin
			s_d.tx_fine_delay_fresh = 1'b0;
		end
		if (bus_rd && bus_sel == SEL_RX_FINE) begin
			s_d.rx_fine_delay_fresh = 1'b0;
		end
		if (tx_load) begin
			s_d.tx_fine_delay_fresh = 1'b1;
		end
		if (rx_load) begin
			s_d.rx_fine_delay_fresh = 1'b1;
		end
		if (meas_clr) begin
			s_d.tx_fine_delay_fresh = 1'b0;
			s_d.rx_fine_delay_fresh = 1'b0;
		end

		// Sticky status, set wins over a write-one clear
		s_d.irq_stat = s_d.irq_stat | irq_events;
		s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_q.sample_prev         <= 1'b0;
			s_q.tx_period           <= PERIOD_W'(`FD_RST_PERIOD);
			s_q.rx_period           <= PERIOD_W'(`FD_RST_PERIOD);
			s_q.tx_fine_delay_fresh <= 1'b0;
			s_q.rx_fine_delay_fresh <= 1'b0;
			s_q.tx_level            <= '0;
			s_q.irq_stat            <= `FD_RST_IRQ;
			s_q.irq_mask            <= `FD_RST_IRQ;
			s_q.ack                 <= 1'b0;
			s_q.rdat                <= `FD_RST_WORD;
			s_q.irq                 <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flops
	assign wb_dat_o = s_q.rdat;
	assign wb_ack_o = s_q.ack;
	assign irq      = s_q.irq;

	// A period write lands in the register one cycle later
	a_period_write: assert property (
		@(posedge core_clk) disable iff (rst)
		(bus_wr && wb_sel_i[0] && bus_sel == SEL_TX_FINE)
		|=> s_q.tx_period == $past(wdat_period))
		else $error("period count not stored");

	// Status read data follows the Tx buffer level with two cycles of delay
	a_tx_level: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && bus_sel == SEL_TX_STATUS
		|=> wb_ack_o && wb_dat_o[OCC_W-1:0] == $past(tx_buf_level, 2))
		else $error("Tx level status wrong");

	// A read of Tx fine delay returns the present sum
	a_tx_delay_read: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && bus_sel == SEL_TX_FINE
		|=> wb_dat_o[`FD_DELAY_LSB +: ACC_W] == $past(tx_fine_delay)
		 && wb_dat_o[`FD_FRESH_BIT] == $past(s_q.tx_fine_delay_fresh))
		else $error("Tx fine delay read wrong");

	// A new sum raises the fresh flag
	a_fresh_set: assert property (
		@(posedge core_clk) disable iff (rst)
		tx_load && !meas_clr |=> s_q.tx_fine_delay_fresh)
		else $error("fresh flag not set by a new sum");

	// A read with no new sum clears the fresh flag
	a_fresh_clear: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && bus_sel == SEL_RX_FINE && !rx_load
		|=> !s_q.rx_fine_delay_fresh)
		else $error("fresh flag not cleared by read");

	// Rx register answers at its own offset with its own fields
	a_rx_offset: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && {wb_adr_i[`FD_ADR_W-1:2], 2'b00} == `FD_OFS_RX_FINE
		|=> wb_ack_o
		 && wb_dat_o[`FD_PERIOD_LSB +: PERIOD_W] == $past(s_q.rx_period)
		 && wb_dat_o[`FD_DELAY_LSB +: ACC_W] == $past(rx_fine_delay))
		else $error("Rx fine delay register wrong");

	// A new Rx sum raises its own fresh flag
	a_rx_fresh_set: assert property (
		@(posedge core_clk) disable iff (rst)
		rx_load && !meas_clr |=> s_q.rx_fine_delay_fresh)
		else $error("Rx fresh flag not set by a new sum");

	// Measurement reset drops both fresh flags, whatever loads
	a_clr_fresh: assert property (
		@(posedge core_clk) disable iff (rst)
		meas_clr |=> !s_q.tx_fine_delay_fresh && !s_q.rx_fine_delay_fresh)
		else $error("fresh flags survived a measurement reset");

	// Only the level field may be nonzero in a status read
	a_status_upper: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && bus_sel == SEL_TX_STATUS
		|=> (wb_dat_o >> OCC_W) == '0)
		else $error("Tx level status has stray bits");

	// The Rx period only changes by a write to its register
	a_rx_period_keep: assert property (
		@(posedge core_clk) disable iff (rst)
		!(bus_wr && wb_sel_i[0] && bus_sel == SEL_RX_FINE)
		|=> $stable(s_q.rx_period))
		else $error("Rx period changed without a write");

	// An enabled new sum raises the interrupt line
	a_irq_on_load: assert property (
		@(posedge core_clk) disable iff (rst)
		(tx_load && s_d.irq_mask[`FD_IRQ_TX_BIT])
		 || (rx_load && s_d.irq_mask[`FD_IRQ_RX_BIT])
		|=> irq)
		else $error("interrupt not raised by an enabled new sum");

	// A Tx read with no new sum clears the Tx fresh flag
	a_tx_fresh_clear: assert property (
		@(posedge core_clk) disable iff (rst)
		bus_rd && bus_sel == SEL_TX_FINE && !tx_load
		|=> !s_q.tx_fine_delay_fresh)
		else $error("Tx fresh flag not cleared by read");

endmodule
`default_nettype wire

/* verilog/fine_delay_pkg.sv */
// Types shared by the fine delay measurement modules
package fine_delay_pkg;

	// Accumulator states, one-hot
	typedef enum logic [1:0] {
		MS_IDLE  = 2'b01,
		MS_ACCUM = 2'b10
	} meas_state_t;

	// Decoded register selection
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_TX_STATUS,
		SEL_TX_FINE,
		SEL_RX_FINE,
		SEL_IRQ_STAT,
		SEL_IRQ_MASK
	} reg_sel_t;

endpackage
